/* File: rtl/ures_pkg.sv */
// ures_pkg: register map, field positions, reset values and counts for
// the receive error status block. assumes a byte-wide status register.
package ures_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_STATUS      = 8'h00;
  localparam logic [7:0]  OFS_RXBUF       = 8'h04;
  localparam logic [7:0]  OFS_DIVISOR     = 8'h08;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int          BIT_PARITY      = 0;
  localparam int          BIT_FRAMING     = 1;
  localparam int          BIT_OVERRUN     = 2;
  localparam int          BIT_ANYERR      = 3;
  localparam int          BIT_BREAK       = 4;
  localparam int          BIT_NINTH       = 5;
  localparam int          BIT_TXBUSY      = 6;
  localparam int          BIT_RESERVED    = 7;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_STATUS      = 8'h00;
  localparam logic [8:0]  RST_RXBUF       = 9'h000;
  localparam int          DIV_W           = 16;
  localparam logic [15:0] RST_DIVISOR     = 16'h0364; // 868 cycles, 115200 baud at 100 MHz
  localparam int          BREAK_BITS      = 10;       // bit times of low line after bad stop
  localparam logic [3:0]  BREAK_CNT_LAST  = 4'(BREAK_BITS);

  // break watcher states
  typedef enum logic [1:0] {
    URES_IDLE  = 2'b01,
    URES_WATCH = 2'b10
  } ures_brk_t;

endpackage

/* File: rtl/ures_bit_timer.sv */
// ures_bit_timer: bit-time tick divider, restartable at frame end.
// assumes divisor is held stable by software between frames.
`timescale 1ns/1ps
`default_nettype none

module ures_bit_timer
  import ures_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 restart,
  input  wire logic [DIV_WIDTH-1:0] divisor,
  output logic                      bitTick
);

  // refuse a divider too narrow to count a bit time
  if (DIV_WIDTH < 2) begin : gen_bad_width
    $error("ures_bit_timer: DIV_WIDTH below 2");
  end

  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  logic [DIV_WIDTH-1:0] cnt_r;
  logic [DIV_WIDTH-1:0] lastCnt;

  // a divisor of zero behaves as one so the tick never stalls
  assign lastCnt = (divisor == '0) ? DIV_WIDTH'(0) : divisor - DIV_WIDTH'(1);

  // count cycles of one bit time, reload on restart
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (restart || cnt_r == '0) begin
      cnt_r <= lastCnt;
    end else begin
      cnt_r <= cnt_r - DIV_WIDTH'(1);
    end
  end

  // one-cycle pulse at the end of each bit time
  assign bitTick = !restart && (cnt_r == '0);

endmodule // ures_bit_timer

`default_nettype wire

/* File: rtl/ures_status.sv */
// ures_status: receive error flags, receive buffer and status register.
// assumes a receiver core delivers each character as a one-cycle pulse
// with its parity and stop-bit checks, and that rxLine is synchronous.
//
// Contract
// - parity mismatch sets parity error flag
// - missing stop bit sets framing flag
// - unread buffer overwritten sets overrun flag
// - status read clears parity, framing, overrun
// - summary flag set when any error set
// - summary flag drops when all clear
// - ten low bit times after bad stop
// - read clears break only if line high
// - pending clear fires when line returns high
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module ures_status
  import ures_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdData,
  // receiver core side
  input  wire logic              rxLine,
  input  wire logic              charValid,
  input  wire logic [8:0]        charData,
  input  wire logic              parityBad,
  input  wire logic              stopBad,
  input  wire logic              txBusy,
  // status outputs
  output logic                   anyRxErr,
  output logic                   lineBreak
);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic statusRd;
  logic rxBufRd;
  logic divWr;

  assign statusRd = regRd && (regAddr == OFS_STATUS);
  assign rxBufRd  = regRd && (regAddr == OFS_RXBUF);
  assign divWr    = regWr && (regAddr == OFS_DIVISOR);

  // ---------------------------------------------------------------
  // bit-time divisor register and timer
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] divisor_r;
  logic             bitTick;
  logic             frameEndLow;

  // software writable bit time in clock cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      divisor_r <= RST_DIVISOR;
    end else if (divWr) begin
      divisor_r <= regWrData[DIV_W-1:0];
    end
  end

  // bad stop with the line still low starts the break watch
  assign frameEndLow = charValid && stopBad && !rxLine;

  ures_bit_timer #(
    .DIV_WIDTH (DIV_W)
  ) uBitTimer (
    .clk     (clk),
    .nrst    (nrst),
    .restart (frameEndLow),
    .divisor (divisor_r),
    .bitTick (bitTick)
  );

  // ---------------------------------------------------------------
  // receive buffer and its full mark
  // ---------------------------------------------------------------
  logic [8:0] rxBuf_r;
  logic       rxFull_r;

  // each received character lands in the buffer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxBuf_r <= RST_RXBUF;
    end else if (charValid) begin
      rxBuf_r <= charData;
    end
  end

  // a new character wins over a buffer read in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxFull_r <= 1'b0;
    end else if (charValid) begin
      rxFull_r <= 1'b1;
    end else if (rxBufRd) begin
      rxFull_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // error flags, set wins over the read clear
  // ---------------------------------------------------------------
  logic parityErr_r;
  logic framingErr_r;
  logic overrunErr_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      parityErr_r <= 1'b0;
    end else if (charValid && parityBad) begin
      parityErr_r <= 1'b1;
    end else if (statusRd) begin
      parityErr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      framingErr_r <= 1'b0;
    end else if (charValid && stopBad) begin
      framingErr_r <= 1'b1;
    end else if (statusRd) begin
      framingErr_r <= 1'b0;
    end
  end

  // overrun when the buffer still holds an unread character
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overrunErr_r <= 1'b0;
    end else if (charValid && rxFull_r && !rxBufRd) begin
      overrunErr_r <= 1'b1;
    end else if (statusRd) begin
      overrunErr_r <= 1'b0;
    end
  end

  // summary follows the three flags with no action of its own
  assign anyRxErr = parityErr_r || framingErr_r || overrunErr_r;

  // ---------------------------------------------------------------
  // break watcher
  // ---------------------------------------------------------------
  ures_brk_t  brkState_r;
  logic [3:0] brkCnt_r;
  logic       brkDetect;

  assign brkDetect = (brkState_r == URES_WATCH) && bitTick && !rxLine
                     && (brkCnt_r == BREAK_CNT_LAST - 4'h1);

  // watch the line for ten whole bit times after a bad stop bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brkState_r <= URES_IDLE;
      brkCnt_r   <= 4'h0;
    end else begin
      unique case (brkState_r)
        URES_IDLE: begin
          if (frameEndLow) begin
            brkState_r <= URES_WATCH;
            brkCnt_r   <= 4'h0;
          end
        end
        URES_WATCH: begin
          if (rxLine || brkDetect) begin
            brkState_r <= URES_IDLE;
          end else if (bitTick) begin
            brkCnt_r <= brkCnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // break flag with deferred clear
  // ---------------------------------------------------------------
  logic break_r;
  logic brkClrPend_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      break_r <= 1'b0;
    end else if (brkDetect) begin
      break_r <= 1'b1;
    end else if (statusRd && rxLine) begin
      break_r <= 1'b0;
    end else if (brkClrPend_r && rxLine) begin
      break_r <= 1'b0;
    end
  end

  // remembers a read that found the line still held low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brkClrPend_r <= 1'b0;
    end else if (brkDetect || rxLine) begin
      brkClrPend_r <= 1'b0;
    end else if (statusRd && break_r) begin
      brkClrPend_r <= 1'b1;
    end
  end

  assign lineBreak = break_r;

  // ---------------------------------------------------------------
  // read data, valid the cycle after the strobe
  // ---------------------------------------------------------------
  logic [7:0] statusVal;

  always_comb begin
    statusVal               = RST_STATUS;
    statusVal[BIT_PARITY]   = parityErr_r;
    statusVal[BIT_FRAMING]  = framingErr_r;
    statusVal[BIT_OVERRUN]  = overrunErr_r;
    statusVal[BIT_ANYERR]   = anyRxErr;
    statusVal[BIT_BREAK]    = break_r;
    statusVal[BIT_NINTH]    = rxBuf_r[8];
    statusVal[BIT_TXBUSY]   = txBusy;
    statusVal[BIT_RESERVED] = 1'b0;
  end

  // unmapped addresses read zero; reads of status return pre-clear value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_STATUS:  regRdData <= {24'h00_0000, statusVal};
        OFS_RXBUF:   regRdData <= {24'h00_0000, rxBuf_r[7:0]};
        OFS_DIVISOR: regRdData <= {16'h0000, divisor_r};
        default:     regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule // ures_status

`default_nettype wire

/* File: testbench/ures_status_sva.sv */
// ures_status_sva: port assertions for the receive error status block.
// assumes buffer and status reads arrive on the plain register port.
`timescale 1ns/1ps
`default_nettype none
module ures_status_sva
  import ures_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdData,
  input wire logic              rxLine,
  input wire logic              charValid,
  input wire logic              parityBad,
  input wire logic              stopBad,
  input wire logic              anyRxErr,
  input wire logic              lineBreak
);
  logic fullR;
  logic pendR;
  wire  bufRd = regRd && regAddr == OFS_RXBUF;
  wire  stRd  = regRd && regAddr == OFS_STATUS;
  // unread character and break clear left pending by a read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fullR <= 1'b0;
      pendR <= 1'b0;
    end else begin
      fullR <= charValid || (fullR && !bufRd);
      pendR <= (stRd && lineBreak && !rxLine) || (pendR && lineBreak);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  err_set_a: assert property (charValid && (parityBad || stopBad) |=> anyRxErr)
    else $error("error flag not set");
  overrun_set_a: assert property (charValid && fullR && !bufRd |=> anyRxErr)
    else $error("overrun not flagged");
  err_hold_a: assert property (anyRxErr && !stRd |=> anyRxErr)
    else $error("summary flag dropped");
  rd_clear_a: assert property (stRd && !charValid |=> !anyRxErr)
    else $error("flags not cleared");
  rd_fields_a: assert property (stRd && !charValid |=> regRdData[31:7] == 25'h0
    && regRdData[4:3] == {$past(lineBreak), $past(anyRxErr)})
    else $error("status read wrong");
  rd_idle_a: assert property (!regRd |=> regRdData == 32'h0)
    else $error("read data not idle");
  brk_hold_a: assert property (lineBreak && !rxLine |=> lineBreak)
    else $error("break dropped");
  brk_clear_a: assert property (stRd && lineBreak && rxLine |=> !lineBreak)
    else $error("break not cleared");
  brk_pend_a: assert property (pendR && rxLine |=> !lineBreak)
    else $error("pending break stuck");
  brk_rise_a: assert property (rxLine && !lineBreak |=> !lineBreak)
    else $error("break on high line");
endmodule // ures_status_sva

bind ures_status ures_status_sva sva (.clk, .nrst, .regAddr, .regRd, .regRdData, .rxLine,
  .charValid, .parityBad, .stopBad, .anyRxErr, .lineBreak);
`default_nettype wire

/* File: testbench/ures_rx_model.sv */
// ures_rx_model: far transmitter and receiver core, frame-end pulses.
// assumes its tasks are called by the bench at clock edges.
`timescale 1ns/1ps
`default_nettype none
module ures_rx_model (
  input  wire logic       clk,
  output logic            rxLine,
  output logic            charValid,
  output logic [8:0]      charData,
  output logic            parityBad,
  output logic            stopBad
);
  initial begin
    rxLine    = 1'b1;
    charValid = 1'b0;
    charData  = 9'h1ff;
    parityBad = 1'b0;
    stopBad   = 1'b0;
  end
  // one character; a lost stop bit leaves the line low
  task automatic send(input logic [8:0] d, input logic pb, input logic sb);
    @(posedge clk);
    charValid <= 1'b1;
    charData  <= d;
    parityBad <= pb;
    stopBad   <= sb;
    rxLine    <= !sb;
    @(posedge clk);
    charValid <= 1'b0;
    charData  <= ~d; // not held after frame end
    parityBad <= 1'b0;
    stopBad   <= 1'b0;
    #1;
  endtask
  // hold the line at a level for n cycles
  task automatic line(input logic v, input int n);
    @(posedge clk);
    rxLine <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask
endmodule // ures_rx_model
`default_nettype wire

/* File: testbench/tb_ures_status.sv */
// tb_ures_status: register-level tests of the receive error status block.
// assumes ures_rx_model stands on the receiver side.
`timescale 1ns/1ps
`default_nettype none
module tb_ures_status
  import ures_pkg::*;
;
  logic              clk;
  logic              nrst;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData;
  logic              regWr;
  logic              regRd;
  logic              txBusy;
  wire  logic [31:0] regRdData;
  wire  logic        rxLine, charValid, parityBad, stopBad, anyRxErr, lineBreak;
  wire  logic [8:0]  charData;
  int                nMismatch = 0;
  int                totalChecks = 0;

  ures_status dut (.clk, .nrst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxLine,
    .charValid, .charData, .parityBad, .stopBad, .txBusy, .anyRxErr, .lineBreak);
  ures_rx_model rxm (.clk, .rxLine, .charValid, .charData, .parityBad, .stopBad);

  // clock and watchdog
  always #5 clk = ~clk;
  initial begin
    #50000;
    nMismatch++;
    tally_and_finish();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  task automatic tally_and_finish();
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    txBusy = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(OFS_STATUS, 32'(RST_STATUS));
    rd(OFS_DIVISOR, 32'(RST_DIVISOR));
    rd(8'h0c, 32'h0);
    wr(OFS_STATUS, 32'hff);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_DIVISOR, 32'h4);
    rd(OFS_DIVISOR, 32'h4);
    rxm.send(9'h1a5, 1'b1, 1'b0);
    chk(32'(anyRxErr), 32'h1);
    rd(OFS_STATUS, 32'h29);
    chk(32'(anyRxErr), 32'h0);
    rd(OFS_RXBUF, 32'ha5);
    rxm.send(9'h03c, 1'b0, 1'b1);
    rxm.line(1'b1, 2);
    rd(OFS_STATUS, 32'h0a);
    @(posedge clk) txBusy <= 1'b1;
    rxm.send(9'h011, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h4c);
    rd(OFS_STATUS, 32'h40);
    @(posedge clk) txBusy <= 1'b0;
    rd(OFS_RXBUF, 32'h11);
    // short low spell, then a real break held through a read
    rxm.send(9'h000, 1'b0, 1'b1);
    rxm.line(1'b0, 30);
    rxm.line(1'b1, 2);
    rd(OFS_STATUS, 32'h0a);
    rxm.send(9'h000, 1'b0, 1'b1);
    rxm.line(1'b0, 50);
    chk(32'(lineBreak), 32'h1);
    rd(OFS_STATUS, 32'h1e);
    chk(32'(lineBreak), 32'h1);
    rxm.line(1'b1, 2);
    chk(32'(lineBreak), 32'h0);
    // break over before the read: read clears it
    rxm.send(9'h000, 1'b0, 1'b1);
    rxm.line(1'b0, 50);
    rxm.line(1'b1, 2);
    chk(32'(lineBreak), 32'h1);
    rd(OFS_STATUS, 32'h1e);
    chk(32'(lineBreak), 32'h0);
    // a status read beside a new character: the set wins
    fork
      rxm.send(9'h001, 1'b1, 1'b0);
      rd(OFS_STATUS, 32'h00);
    join
    rd(OFS_STATUS, 32'h0d);
    tally_and_finish();
  end
endmodule // tb_ures_status
`default_nettype wire
